// file: verilog/cer_pkg.sv
// constants for the controller enable and reset register block
// assumes a 10 MHz system clock and an apb master with 32-bit data
package cer_pkg;
  localparam int CLK_PERIOD_NS = 100;
  localparam int ENABLE_TIME_NS = 500;
  localparam int RESET_TIME_NS = 1000;
  localparam int ENABLE_CYC = (ENABLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_CYC = (RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 4;
  localparam int ADDR_W = 16;
  localparam logic [15:0] FEATURE_OFS = 16'h0000;
  localparam logic [15:0] CONFIG_OFS = 16'h0014;
  localparam logic [15:0] STATUS_OFS = 16'h001c;
  localparam logic [15:0] AQA_OFS = 16'h0024;
  localparam logic [15:0] ASQ_OFS = 16'h0028;
  localparam logic [15:0] ACQ_OFS = 16'h0030;
  localparam logic [15:0] FSET_OFS = 16'h0040;
  localparam logic [15:0] DOORBELL_OFS = 16'h1000;
  localparam int EN_BIT = 0;
  localparam int CSS_LSB = 4;
  localparam int CSS_MSB = 6;
  localparam int READY_BIT = 0;
  localparam int TIMEOUT_LSB = 0;
  localparam int TIMEOUT_MSB = 7;
  localparam int CSS_SUP_BIT = 8;
  localparam logic [2:0] CSS_BASIC = 3'h0;
  localparam logic [7:0] READY_WAIT_TIMEOUT = 8'h01;
  localparam logic [31:0] QREG_RST = 32'h0000_0000;
  localparam logic [31:0] FSET_RST = 32'h0000_0000;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ENABLING = 2'b01,
    ST_READY = 2'b10,
    ST_RESET = 2'b11
  } cer_state_e;
endpackage

// file: verilog/cer_controller_enable_reset.sv
// configuration low field, status ready flag and controller reset sequencing
// assumes a command engine on sys_clk_in and an apb master on the same clock
//
// The APB interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module cer_controller_enable_reset (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  // apb slave
  input wire logic apb_psel_in,
  input wire logic apb_penable_in,
  input wire logic apb_pwrite_in,
  input wire logic [15:0] apb_paddr_in,
  input wire logic [31:0] apb_pwdata_in,
  output logic [31:0] apb_prdata_out,
  output logic apb_pready_out,
  output logic apb_pslverr_out,
  // command engine
  input wire logic cq_post_req_in,
  input wire logic flush_done_in,
  output logic engine_run_out,
  output logic [2:0] io_command_set_select_out,
  output logic queue_reset_out,
  output logic sq_tail_valid_out,
  output logic [15:0] sq_tail_out,
  output logic cq_post_out,
  output logic [31:0] feature_setting_out
);
  function automatic logic mapped(input logic [15:0] a);
    mapped = (a == cer_pkg::FEATURE_OFS) || (a == cer_pkg::CONFIG_OFS) ||
             (a == cer_pkg::STATUS_OFS) || (a == cer_pkg::AQA_OFS) ||
             (a == cer_pkg::ASQ_OFS) || (a == cer_pkg::ACQ_OFS) ||
             (a == cer_pkg::FSET_OFS) || (a == cer_pkg::DOORBELL_OFS);
  endfunction

  logic en_reg, en_next;
  logic [2:0] css_reg, css_next;
  logic [31:0] aqa_reg, aqa_next;
  logic [31:0] asq_reg, asq_next;
  logic [31:0] acq_reg, acq_next;
  logic [31:0] fset_reg, fset_next;
  logic ready_reg, ready_next;
  logic qrst_reg, qrst_next;
  logic [cer_pkg::CNT_W-1:0] cnt_reg, cnt_next;
  cer_pkg::cer_state_e state_reg, state_next;
  logic [31:0] rdata_reg, rdata_next;
  logic err_reg, err_next;
  logic tail_vld_reg, tail_vld_next;
  logic [15:0] tail_reg, tail_next;
  logic setup, wr, ctrl_rst;

  // zero wait states: data and error are prepared in the setup cycle
  assign apb_pready_out = 1'b1;
  assign setup = apb_psel_in && !apb_penable_in;
  assign wr = apb_psel_in && apb_penable_in && apb_pwrite_in;
  assign ctrl_rst = (state_next == cer_pkg::ST_RESET) && (state_reg != cer_pkg::ST_RESET);

  // configuration group
  always_comb begin
    en_next = en_reg;
    css_next = css_reg;
    aqa_next = aqa_reg;
    asq_next = asq_reg;
    acq_next = acq_reg;
    fset_next = fset_reg;
    if (wr && apb_paddr_in == cer_pkg::CONFIG_OFS) begin
      en_next = apb_pwdata_in[cer_pkg::EN_BIT];
      // a select change while running would split the io queues across sets
      if (!en_reg) begin
        css_next = apb_pwdata_in[cer_pkg::CSS_MSB:cer_pkg::CSS_LSB];
      end
    end
    // admin queue registers are frozen while running and untouched by controller reset
    if (wr && !en_reg) begin
      if (apb_paddr_in == cer_pkg::AQA_OFS) begin
        aqa_next = apb_pwdata_in;
      end
      if (apb_paddr_in == cer_pkg::ASQ_OFS) begin
        asq_next = apb_pwdata_in;
      end
      if (apb_paddr_in == cer_pkg::ACQ_OFS) begin
        acq_next = apb_pwdata_in;
      end
    end
    if (wr && apb_paddr_in == cer_pkg::FSET_OFS) begin
      fset_next = apb_pwdata_in;
    end
    if (ctrl_rst) begin
      fset_next = cer_pkg::FSET_RST;
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      en_reg <= 1'b0;
      css_reg <= cer_pkg::CSS_BASIC;
      aqa_reg <= cer_pkg::QREG_RST;
      asq_reg <= cer_pkg::QREG_RST;
      acq_reg <= cer_pkg::QREG_RST;
      fset_reg <= cer_pkg::FSET_RST;
    end else begin
      en_reg <= en_next;
      css_reg <= css_next;
      aqa_reg <= aqa_next;
      asq_reg <= asq_next;
      acq_reg <= acq_next;
      fset_reg <= fset_next;
    end
  end

  // enable and reset sequencer
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    ready_next = ready_reg;
    case (state_reg)
      cer_pkg::ST_IDLE: begin
        if (en_reg) begin
          state_next = cer_pkg::ST_ENABLING;
          cnt_next = cer_pkg::CNT_W'(cer_pkg::ENABLE_CYC - 1);
        end
      end
      cer_pkg::ST_ENABLING: begin
        if (!en_reg) begin
          state_next = cer_pkg::ST_RESET;
          cnt_next = cer_pkg::CNT_W'(cer_pkg::RESET_CYC - 1);
        end else if (cnt_reg == '0) begin
          state_next = cer_pkg::ST_READY;
          ready_next = 1'b1;
        end else begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      cer_pkg::ST_READY: begin
        if (!en_reg) begin
          state_next = cer_pkg::ST_RESET;
          cnt_next = cer_pkg::CNT_W'(cer_pkg::RESET_CYC - 1);
        end
      end
      cer_pkg::ST_RESET: begin
        // ready holds until the engine has flushed posted data
        if (cnt_reg != '0) begin
          cnt_next = cnt_reg - 1'b1;
        end else if (flush_done_in) begin
          state_next = cer_pkg::ST_IDLE;
          ready_next = 1'b0;
        end
      end
      default: begin
        state_next = cer_pkg::ST_IDLE;
        ready_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_reg <= cer_pkg::ST_IDLE;
      cnt_reg <= '0;
      ready_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      ready_reg <= ready_next;
    end
  end

  // bus read path and engine strobes
  always_comb begin
    rdata_next = rdata_reg;
    err_next = err_reg;
    qrst_next = ctrl_rst;
    tail_vld_next = 1'b0;
    tail_next = tail_reg;
    if (setup) begin
      err_next = !mapped(apb_paddr_in);
      rdata_next = 32'h0000_0000;
      case (apb_paddr_in)
        cer_pkg::FEATURE_OFS: begin
          rdata_next[cer_pkg::TIMEOUT_MSB:cer_pkg::TIMEOUT_LSB] = cer_pkg::READY_WAIT_TIMEOUT;
          rdata_next[cer_pkg::CSS_SUP_BIT] = 1'b1;
        end
        cer_pkg::CONFIG_OFS: begin
          // bits 3:1 stay zero
          rdata_next[cer_pkg::CSS_MSB:cer_pkg::CSS_LSB] = css_reg;
          rdata_next[cer_pkg::EN_BIT] = en_reg;
        end
        cer_pkg::STATUS_OFS: rdata_next[cer_pkg::READY_BIT] = ready_reg;
        cer_pkg::AQA_OFS: rdata_next = aqa_reg;
        cer_pkg::ASQ_OFS: rdata_next = asq_reg;
        cer_pkg::ACQ_OFS: rdata_next = acq_reg;
        cer_pkg::FSET_OFS: rdata_next = fset_reg;
        default: rdata_next = 32'h0000_0000;
      endcase
    end
    // doorbells are honoured only once ready and still enabled
    if (wr && apb_paddr_in == cer_pkg::DOORBELL_OFS && state_reg == cer_pkg::ST_READY && en_reg) begin
      tail_vld_next = 1'b1;
      tail_next = apb_pwdata_in[15:0];
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_reg <= 32'h0000_0000;
      err_reg <= 1'b0;
      qrst_reg <= 1'b0;
      tail_vld_reg <= 1'b0;
      tail_reg <= 16'h0000;
    end else begin
      rdata_reg <= rdata_next;
      err_reg <= err_next;
      qrst_reg <= qrst_next;
      tail_vld_reg <= tail_vld_next;
      tail_reg <= tail_next;
    end
  end

  assign apb_prdata_out = rdata_reg;
  assign apb_pslverr_out = err_reg && apb_psel_in && apb_penable_in;
  assign engine_run_out = en_reg && state_reg == cer_pkg::ST_READY;
  assign cq_post_out = cq_post_req_in && engine_run_out;
  assign io_command_set_select_out = css_reg;
  assign queue_reset_out = qrst_reg;
  assign sq_tail_valid_out = tail_vld_reg;
  assign sq_tail_out = tail_reg;
  assign feature_setting_out = fset_reg;

  css_frozen_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    $changed(css_reg) |-> !$past(en_reg))
    else $error("command set select changed while enabled");

  css_stable_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    engine_run_out ##1 engine_run_out |-> $stable(io_command_set_select_out))
    else $error("command set changed while running");

  doorbell_gate_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    sq_tail_valid_out |-> $past(state_reg == cer_pkg::ST_READY && en_reg))
    else $error("doorbell taken while not ready");

  no_post_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    !en_reg |-> !cq_post_out && !engine_run_out && !sq_tail_valid_out)
    else $error("activity while run bit clear");

  queue_reset_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    $fell(en_reg) && state_reg == cer_pkg::ST_READY |=> queue_reset_out ##1 !queue_reset_out)
    else $error("controller reset pulse missing");

  admin_keep_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    queue_reset_out |-> $stable(aqa_reg) && $stable(asq_reg) && $stable(acq_reg))
    else $error("admin queue registers changed by reset");

  feature_dflt_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    queue_reset_out |-> feature_setting_out == cer_pkg::FSET_RST)
    else $error("feature setting not restored");

  flush_wait_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    state_reg == cer_pkg::ST_RESET && ready_reg && !flush_done_in |=> ready_reg)
    else $error("ready dropped before flush");

  ready_drop_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    $fell(ready_reg) |-> state_reg == cer_pkg::ST_IDLE && $past(flush_done_in))
    else $error("ready dropped early");

  ready_rise_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    state_reg == cer_pkg::ST_ENABLING && cnt_reg == '0 && en_reg |=> ready_reg && engine_run_out)
    else $error("ready not raised when enabled");

  status_bit_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    setup && apb_paddr_in == cer_pkg::STATUS_OFS |=> apb_prdata_out[0] == $past(ready_reg))
    else $error("status ready bit wrong");

  rsvd_zero_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    setup && apb_paddr_in == cer_pkg::CONFIG_OFS |=> apb_prdata_out[3:1] == 3'h0)
    else $error("reserved config bits not zero");

  reset_low_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    state_reg == cer_pkg::ST_RESET && !ready_reg |=> !ready_reg)
    else $error("ready rose during controller reset");

  en_set_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    wr && apb_paddr_in == cer_pkg::CONFIG_OFS && apb_pwdata_in[cer_pkg::EN_BIT] |=> en_reg)
    else $error("run bit not set by write");

  en_clear_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    wr && apb_paddr_in == cer_pkg::CONFIG_OFS && !apb_pwdata_in[cer_pkg::EN_BIT] |=> !en_reg)
    else $error("run bit not cleared by write");

  enable_start_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    state_reg == cer_pkg::ST_IDLE && en_reg |=> state_reg == cer_pkg::ST_ENABLING && !ready_reg)
    else $error("enable sequence not started");

  enabling_count_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    state_reg == cer_pkg::ST_ENABLING && cnt_reg != '0 && en_reg |=> state_reg == cer_pkg::ST_ENABLING && !ready_reg)
    else $error("ready raised before enable delay");

  enabling_low_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    state_reg == cer_pkg::ST_ENABLING |-> !ready_reg)
    else $error("ready high while enabling");

  ready_state_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    state_reg == cer_pkg::ST_READY |-> ready_reg)
    else $error("ready low while running");

  idle_low_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    state_reg == cer_pkg::ST_IDLE |-> !ready_reg)
    else $error("ready high while idle");

  qrst_pulse_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    queue_reset_out |-> state_reg == cer_pkg::ST_RESET ##1 !queue_reset_out)
    else $error("queue reset not a single pulse");

  reset_min_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    state_reg == cer_pkg::ST_RESET && cnt_reg != '0 |=> state_reg == cer_pkg::ST_RESET)
    else $error("controller reset cut short");

  flush_hold_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    state_reg == cer_pkg::ST_RESET && !flush_done_in |=> state_reg == cer_pkg::ST_RESET)
    else $error("controller reset left before flush");

  reset_exit_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    state_reg == cer_pkg::ST_RESET && cnt_reg == '0 && flush_done_in |=> state_reg == cer_pkg::ST_IDLE)
    else $error("controller reset did not end");

  run_gate_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    state_reg != cer_pkg::ST_READY |-> !engine_run_out)
    else $error("engine running while not ready");

  post_gate_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    !engine_run_out |-> !cq_post_out)
    else $error("completion posted while stopped");

  doorbell_take_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    wr && apb_paddr_in == cer_pkg::DOORBELL_OFS && engine_run_out |=> sq_tail_valid_out)
    else $error("doorbell lost while running");

  admin_lock_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    en_reg |=> $stable(aqa_reg) && $stable(asq_reg) && $stable(acq_reg))
    else $error("admin queue registers changed while enabled");

  fset_write_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    wr && apb_paddr_in == cer_pkg::FSET_OFS && !ctrl_rst |=> feature_setting_out == $past(apb_pwdata_in))
    else $error("feature setting write lost");

  config_read_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    setup && apb_paddr_in == cer_pkg::CONFIG_OFS |=>
    apb_prdata_out[cer_pkg::CSS_MSB:cer_pkg::CSS_LSB] == $past(css_reg))
    else $error("select field read wrong");
endmodule // cer_controller_enable_reset
`default_nettype wire

// file: dv/cer_engine_model.sv
// command engine stand-in: answers each queue reset with a late flush
// assumes queue_reset_in is a one-cycle pulse on clk_in
`timescale 1ns/10ps
`default_nettype none
module cer_engine_model (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // engine side
  input wire logic queue_reset_in,
  output logic flush_done_out
);
  logic [4:0] cnt_reg;
  // slow flush, so a ready that falls too early shows up
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_reg <= 5'h00;
      flush_done_out <= 1'b0;
    end else if (queue_reset_in) begin
      cnt_reg <= 5'h14;
      flush_done_out <= 1'b0;
    end else if (cnt_reg != 5'h00) begin
      cnt_reg <= cnt_reg - 5'h01;
      flush_done_out <= (cnt_reg == 5'h01);
    end
  end
endmodule // cer_engine_model
`default_nettype wire

// file: dv/cer_controller_enable_reset_bench.sv
// bench: register rows, enable, doorbell, controller reset, reset just after enable
// assumes zero-wait apb answers and the engine model on queue_reset_out
`timescale 1ns/10ps
`default_nettype none
module cer_controller_enable_reset_bench;
  typedef struct {logic [15:0] a; logic [31:0] d; logic [31:0] m; logic [31:0] x; logic e;} cer_row_s;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pw = 1'b0;
  logic post_req = 1'b0;
  logic [15:0] pa = 16'h0000;
  logic [31:0] pwd = 32'h0000_0000;
  logic [31:0] prd, fset, q;
  logic prdy, perr, flush, run, qr, tv, post, e;
  logic [2:0] io_command_set_select;
  logic [15:0] tail;
  cer_row_s rows [6];
  int n_fail = 0;
  int check_count = 0;
  int k, seen;
  always #50 clk = ~clk;
  cer_controller_enable_reset dut_u (.sys_clk_in(clk), .reset_n_in(rst_n), .apb_psel_in(psel),
    .apb_penable_in(pen), .apb_pwrite_in(pw), .apb_paddr_in(pa), .apb_pwdata_in(pwd),
    .apb_prdata_out(prd), .apb_pready_out(prdy), .apb_pslverr_out(perr), .cq_post_req_in(post_req),
    .flush_done_in(flush), .engine_run_out(run), .io_command_set_select_out(io_command_set_select),
    .queue_reset_out(qr), .sq_tail_valid_out(tv), .sq_tail_out(tail), .cq_post_out(post),
    .feature_setting_out(fset));
  cer_engine_model eng_u (.clk_in(clk), .rst_n_in(rst_n), .queue_reset_in(qr), .flush_done_out(flush));
  task automatic give_verdict;
    $display("checks %0d, errors %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d);
    int j;
    @(posedge clk);
    psel <= 1'b1;
    pw <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    for (j = 0; j < 20; j++) begin
      @(posedge clk);
      if (prdy === 1'b1) break;
    end
    if (j == 20) begin
      chk(0, 1, "pready timeout");
      give_verdict();
    end
    q = prd;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic poll_rdy(input logic v);
    int j;
    for (j = 0; j < 40; j++) begin
      xfer(1'b0, cer_pkg::STATUS_OFS, 32'h0);
      if (q[0] === v) break;
    end
    chk(j < 40, 1, "ready level not reached");
    if (j == 40) give_verdict();
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    chk(0, 1, "run timeout");
    give_verdict();
  end
  initial begin
    // only the basic set is reported as supported, so the host selects it
    rows[0] = '{cer_pkg::CONFIG_OFS, 32'h0000_000e, 32'h0000_007f, 32'h0000_0000, 1'b0};
    rows[1] = '{cer_pkg::AQA_OFS, 32'h1234_5678, 32'hffff_ffff, 32'h1234_5678, 1'b0};
    rows[2] = '{cer_pkg::STATUS_OFS, 32'hffff_ffff, 32'h0000_0001, 32'h0, 1'b0};
    rows[3] = '{cer_pkg::FEATURE_OFS, 32'h0, 32'h0000_01ff, 32'h0000_0101, 1'b0};
    rows[4] = '{cer_pkg::FSET_OFS, 32'h0000_00a5, 32'hffff_ffff, 32'h0000_00a5, 1'b0};
    rows[5] = '{16'h0100, 32'h0000_0001, 32'hffff_ffff, 32'h0, 1'b1};
    repeat (20) @(posedge clk);
    chk(prdy, 1, "pready in reset");
    rst_n <= 1'b1;
    foreach (rows[r]) begin
      xfer(1'b1, rows[r].a, rows[r].d);
      xfer(1'b0, rows[r].a, 32'h0);
      chk(q & rows[r].m, rows[r].x, "register read");
      chk(e, rows[r].e, "slave error");
    end
    chk(io_command_set_select, 3'h0, "select to queues");
    chk(fset, 32'h0000_00a5, "feature setting output");
    xfer(1'b1, cer_pkg::CONFIG_OFS, 32'h1);
    poll_rdy(1'b1);
    chk(run, 1, "engine not running");
    xfer(1'b1, cer_pkg::DOORBELL_OFS, 32'h5);
    seen = 0;
    for (k = 0; k < 4; k++) begin
      @(posedge clk);
      if (tv === 1'b1) seen++;
      if (tv === 1'b1) chk(tail, 16'h5, "doorbell tail");
    end
    chk(seen, 1, "doorbell pulse");
    // while running the host rewrites only the run bit, select kept as it was
    xfer(1'b1, cer_pkg::CONFIG_OFS, 32'h1);
    xfer(1'b0, cer_pkg::AQA_OFS, 32'h0);
    chk(q, 32'h1234_5678, "admin reg changed while on");
    chk(io_command_set_select, 3'h0, "select changed while on");
    post_req <= 1'b1;
    @(posedge clk);
    chk(post, 1, "no post while running");
    xfer(1'b1, cer_pkg::CONFIG_OFS, 32'h0);
    seen = 0;
    for (k = 0; k < 8; k++) begin
      @(posedge clk);
      if (qr === 1'b1) seen++;
    end
    chk(seen, 1, "queue reset pulse");
    chk(post, 0, "post while disabled");
    chk(fset, cer_pkg::FSET_RST, "feature output not restored");
    xfer(1'b0, cer_pkg::FSET_OFS, 32'h0);
    chk(q, cer_pkg::FSET_RST, "feature not restored");
    xfer(1'b0, cer_pkg::AQA_OFS, 32'h0);
    chk(q, 32'h1234_5678, "admin reg lost");
    xfer(1'b0, cer_pkg::STATUS_OFS, 32'h0);
    chk(q[0], 1, "ready fell too early");
    poll_rdy(1'b0);
    chk(flush, 1, "ready fell before flush");
    xfer(1'b1, cer_pkg::CONFIG_OFS, 32'h1);
    rst_n <= 1'b0;
    @(posedge clk);
    chk({run, qr, tv, post, prdy}, 5'h01, "outputs in reset");
    chk(fset, cer_pkg::FSET_RST, "feature output in reset");
    rst_n <= 1'b1;
    xfer(1'b0, cer_pkg::CONFIG_OFS, 32'h0);
    chk(q & 32'h7f, 32'h0, "config after reset");
    give_verdict();
  end
endmodule // cer_controller_enable_reset_bench
`default_nettype wire
